/* hdl/hscpd_pkg.sv */
// constants, types and carriers for the host strap and port decode block
// ----------------------------------------------------------------------
// Operation
// - sample eight host lines at reset release
// - host line 0 picks bus interface
// - one selects isa-style, zero alternate bus
// - host line 1 gates bios rom decode
// - rom window c0000 to c7fff when enabled
// - host line 2 picks pixel clock source
// - one: oscillator inputs; zero: select outputs
// - host line 3 picks memory clock rate
// - one: 50.350 on clock zero, else 56.644
// - host line 4 picks zero-wait pin mode
// - lines 5 to 7 only readable status
// - all eight straps readable in register
// - weak pull-ups on every host line
// - reset disables all extension features
// - extension writes need both enable groups
// - standard register bits untouched by extensions
// - ports 3c6-3c9 give palette strobes
// - optional 83c6-83c9 palette strobes
// - only 8-bit host transfers accepted
// - internal rom decode drives select, transceivers
// - zero-wait write ends cycle at once
// ----------------------------------------------------------------------
package hscpd_pkg;

	// strap bit positions
	localparam int STRAP_BUS = 0;
	localparam int STRAP_ROM = 1;
	localparam int STRAP_OSC = 2;
	localparam int STRAP_MCLK = 3;
	localparam int STRAP_ZWS = 4;

	// register offsets
	localparam logic [7:0] REG_EN_A = 8'h00;
	localparam logic [7:0] REG_EN_B = 8'h01;
	localparam logic [7:0] REG_STRAP = 8'h02;
	localparam logic [7:0] REG_EXT_CTRL = 8'h03;
	localparam logic [7:0] REG_STD_MISC = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h05;

	// field positions
	localparam int EN_BIT = 0;
	localparam int EXT_DAC_BIT = 0;
	localparam int EXT_WBUF_BIT = 1;
	localparam int MISC_CLK_LO = 2;

	// address windows
	localparam logic [19:0] ROM_LO = 20'hc0000;
	localparam logic [19:0] ROM_HI = 20'hc7fff;
	localparam logic [19:0] VMEM_LO = 20'ha0000;
	localparam logic [19:0] VMEM_HI = 20'hbffff;
	localparam logic [15:0] PAL_LO = 16'h03c6;
	localparam logic [15:0] PAL_HI = 16'h03c9;
	localparam logic [15:0] PALX_LO = 16'h83c6;
	localparam logic [15:0] PALX_HI = 16'h83c9;

	// wait states on non zero-wait display cycles
	localparam logic [3:0] WAIT_CYCLES = 4'h3;
	localparam logic [3:0] WAIT_LAST = 4'h1;

	typedef enum logic [1:0] {
		HSCPD_IDLE = 2'b00,
		HSCPD_WAIT = 2'b01,
		HSCPD_HOLD = 2'b10
	} hscpd_cyc_t;

	typedef struct packed {
		logic [19:0] mem_addr;
		logic [15:0] io_addr;
		logic memr;
		logic memw;
		logic iord;
		logic iowr;
	} hscpd_host_bus_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} hscpd_reg_req_t;

endpackage : hscpd_pkg

/* hdl/hscpd_sync.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module hscpd_sync #(
	parameter int W = 8
) (
	input wire logic core_clk_i,
	input wire logic ce_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	import hscpd_pkg::*;

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} hscpd_sync_t;

	hscpd_sync_t st;
	hscpd_sync_t next_st;

	always_comb begin
		next_st.s1 = d_i;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge core_clk_i) begin
		if (ce_i) begin
			st <= next_st;
		end
	end

	assign q_o = st.s2;

endmodule : hscpd_sync

/* hdl/hscpd_top.sv */
// host strap capture, extension lock and port decode
`timescale 1ns/1ps
module hscpd_top (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire hscpd_pkg::hscpd_host_bus_t host_bus_i,
	input wire logic [7:0] host_addr_data_lines_i,
	output logic [7:0] host_addr_data_lines_o,
	output logic [7:0] host_addr_data_lines_oe_o,
	output logic [7:0] host_addr_data_pullup_o,
	input wire hscpd_pkg::hscpd_reg_req_t reg_req_i,
	output logic [7:0] reg_rdata_o,
	output logic bus_is_isa_o,
	output logic pix_clk_from_osc_o,
	output logic [1:0] upper_clock_pins_o,
	output logic [1:0] upper_clock_pins_oe_o,
	output logic mem_clk_from_one_o,
	output logic pal_rd_n_o,
	output logic pal_wr_n_o,
	output logic bios_rom_select_n_o,
	output logic xcvr_en_n_o,
	output logic zero_wait_indication_o,
	output logic rdy_o,
	output logic host_16bit_claim_o
);
	import hscpd_pkg::*;

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] strap;
		logic en_a;
		logic en_b;
		logic [7:0] ext_ctrl;
		logic [7:0] std_misc;
		logic [7:0] rdata;
		logic pal_rd;
		logic pal_wr;
		logic rom_hit;
		logic zero_wait_indication;
		logic waiting;
		hscpd_cyc_t cyc;
		logic [3:0] wcnt;
		logic prev_memr;
		logic prev_memw;
	} hscpd_state_t;

	hscpd_state_t st;
	hscpd_state_t next_st;

	hscpd_host_bus_t host_q;
	logic [7:0] ad_q;

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	hscpd_sync #(
		.W($bits(hscpd_host_bus_t))
	) u_bus_sync (
		.core_clk_i(core_clk_i),
		.ce_i(ce_i),
		.d_i(host_bus_i),
		.q_o(host_q)
	);

	hscpd_sync #(
		.W(8)
	) u_ad_sync (
		.core_clk_i(core_clk_i),
		.ce_i(ce_i),
		.d_i(host_addr_data_lines_i),
		.q_o(ad_q)
	);

	// ------------------------------------------------------------------
	// decode
	// ------------------------------------------------------------------
	logic is_isa;
	logic rom_dec_en;
	logic zws_pins;
	logic zws_active;
	logic ext_unlocked;
	logic rom_win;
	logic vmem_win;
	logic pal_win;
	logic palx_win;
	logic pal_hit;
	logic memr_rise;
	logic memw_rise;

	assign is_isa = st.strap[STRAP_BUS];
	assign rom_dec_en = st.strap[STRAP_ROM] & is_isa;
	assign zws_pins = ~st.strap[STRAP_ZWS];
	assign zws_active = zws_pins & st.ext_ctrl[EXT_WBUF_BIT];
	assign ext_unlocked = st.en_a & st.en_b;

	assign rom_win = (host_q.mem_addr >= ROM_LO) && (host_q.mem_addr <= ROM_HI);
	assign vmem_win = (host_q.mem_addr >= VMEM_LO) && (host_q.mem_addr <= VMEM_HI);
	assign pal_win = (host_q.io_addr >= PAL_LO) && (host_q.io_addr <= PAL_HI);
	assign palx_win = (host_q.io_addr >= PALX_LO) && (host_q.io_addr <= PALX_HI);
	assign pal_hit = pal_win | (palx_win & st.ext_ctrl[EXT_DAC_BIT]);

	assign memr_rise = host_q.memr & ~st.prev_memr;
	assign memw_rise = host_q.memw & ~st.prev_memw;

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.rdata = 8'h00;
		next_st.zero_wait_indication = 1'b0;
		next_st.prev_memr = host_q.memr;
		next_st.prev_memw = host_q.memw;
		if (!nrst_i) begin
			next_st = '0;
			// follows the lines until release, then held
			next_st.strap = ad_q;
			// extension features and both groups off
			next_st.en_a = 1'b0;
			next_st.en_b = 1'b0;
			next_st.ext_ctrl = 8'h00;
		end else begin
			// register writes; strap has no write path
			if (reg_req_i.wr) begin
				case (reg_req_i.addr)
					REG_EN_A: begin
						next_st.en_a = reg_req_i.wdata[EN_BIT];
					end
					REG_EN_B: begin
						next_st.en_b = reg_req_i.wdata[EN_BIT];
					end
					REG_EXT_CTRL: begin
						if (ext_unlocked) begin
							next_st.ext_ctrl = reg_req_i.wdata;
						end
					end
					REG_STD_MISC: begin
						// written only by its own port
						next_st.std_misc = reg_req_i.wdata;
					end
					default: begin
						next_st.std_misc = st.std_misc;
					end
				endcase
			end

			// register reads, data in the next cycle
			if (reg_req_i.rd) begin
				case (reg_req_i.addr)
					REG_EN_A: begin
						next_st.rdata = {7'h00, st.en_a};
					end
					REG_EN_B: begin
						next_st.rdata = {7'h00, st.en_b};
					end
					REG_STRAP: begin
						next_st.rdata = st.strap;
					end
					REG_EXT_CTRL: begin
						next_st.rdata = st.ext_ctrl;
					end
					REG_STD_MISC: begin
						next_st.rdata = st.std_misc;
					end
					REG_STATUS: begin
						next_st.rdata = {3'h0, zws_active, ext_unlocked,
							st.waiting, st.cyc};
					end
					default: begin
						next_st.rdata = 8'h00;
					end
				endcase
			end

			// palette strobes
			next_st.pal_rd = host_q.iord & pal_hit;
			next_st.pal_wr = host_q.iowr & pal_hit;

			// bios rom read decode
			next_st.rom_hit = host_q.memr & rom_win & rom_dec_en;

			// display memory cycle control
			case (st.cyc)
				HSCPD_IDLE: begin
					if (memw_rise && vmem_win) begin
						if (zws_active) begin
							next_st.zero_wait_indication = 1'b1;
							next_st.cyc = HSCPD_HOLD;
						end else begin
							next_st.waiting = 1'b1;
							next_st.wcnt = WAIT_CYCLES;
							next_st.cyc = HSCPD_WAIT;
						end
					end else if (memr_rise && vmem_win) begin
						next_st.waiting = 1'b1;
						next_st.wcnt = WAIT_CYCLES;
						next_st.cyc = HSCPD_WAIT;
					end
				end
				HSCPD_WAIT: begin
					if (st.wcnt == WAIT_LAST) begin
						next_st.waiting = 1'b0;
						next_st.cyc = HSCPD_HOLD;
					end else begin
						next_st.wcnt = st.wcnt - WAIT_LAST;
					end
				end
				HSCPD_HOLD: begin
					if (!host_q.memr && !host_q.memw) begin
						next_st.cyc = HSCPD_IDLE;
					end
				end
				default: begin
					next_st.waiting = 1'b0;
					next_st.cyc = HSCPD_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (ce_i || !nrst_i) begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	// lines are only sampled here, never driven
	assign host_addr_data_lines_o = 8'h00;
	assign host_addr_data_lines_oe_o = 8'h00;
	assign host_addr_data_pullup_o = 8'hff;

	assign reg_rdata_o = st.rdata;
	assign bus_is_isa_o = is_isa;
	assign pix_clk_from_osc_o = st.strap[STRAP_OSC];
	// select outputs for an external generator when strap is zero
	assign upper_clock_pins_o = st.std_misc[MISC_CLK_LO+:2];
	assign upper_clock_pins_oe_o = {2{~st.strap[STRAP_OSC]}};
	assign mem_clk_from_one_o = ~st.strap[STRAP_MCLK];

	assign pal_rd_n_o = ~st.pal_rd;
	assign pal_wr_n_o = ~st.pal_wr;
	assign xcvr_en_n_o = ~st.rom_hit;
	// rom select shares its pin with zero-wait in that mode
	assign bios_rom_select_n_o = ~(st.rom_hit | (zws_pins & st.zero_wait_indication));
	assign zero_wait_indication_o = st.zero_wait_indication;
	assign rdy_o = ~st.waiting;
	// never claims a 16-bit transfer
	assign host_16bit_claim_o = 1'b0;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!nrst_i);

	chk_strap_capture: assert property (
		$rose(nrst_i) |-> st.strap == $past(ad_q)
	) else $error("strap not taken at reset release");

	chk_strap_hold: assert property (
		$past(nrst_i) |-> $stable(st.strap)
	) else $error("strap changed outside reset");

	chk_ext_reset: assert property (
		$rose(nrst_i) |-> (st.ext_ctrl == 8'h00) && !st.en_a && !st.en_b
	) else $error("extension state not cleared by reset");

	chk_ext_lock: assert property (
		ce_i && reg_req_i.wr && reg_req_i.addr == REG_EXT_CTRL && !ext_unlocked
		|=> $stable(st.ext_ctrl)
	) else $error("locked extension register was written");

	chk_strap_read: assert property (
		ce_i && reg_req_i.rd && reg_req_i.addr == REG_STRAP
		|=> reg_rdata_o == $past(st.strap)
	) else $error("strap readback wrong");

	chk_pal_read: assert property (
		ce_i && host_q.iord && pal_win |=> !pal_rd_n_o
	) else $error("palette read strobe missing");

	chk_pal_ext: assert property (
		ce_i && !reg_req_i.wr && host_q.iowr && palx_win && !st.ext_ctrl[EXT_DAC_BIT]
		|=> pal_wr_n_o
	) else $error("extended palette port decoded while off");

	chk_rom_select: assert property (
		ce_i && host_q.memr && rom_win && rom_dec_en
		|=> !bios_rom_select_n_o && !xcvr_en_n_o
	) else $error("rom select not driven");

	chk_zws_write: assert property (
		ce_i && !reg_req_i.wr && st.cyc == HSCPD_IDLE && memw_rise && vmem_win
		&& zws_active |=> zero_wait_indication_o && rdy_o && !bios_rom_select_n_o
	) else $error("zero-wait write not ended at once");

	chk_clock_pins: assert property (
		$past(nrst_i) |-> $stable(upper_clock_pins_oe_o) && $stable(mem_clk_from_one_o)
		&& $stable(bus_is_isa_o) && $stable(pix_clk_from_osc_o)
	) else $error("strap driven pin mode changed outside reset");

	chk_wait_len: assert property (
		ce_i && st.cyc == HSCPD_IDLE && memr_rise && vmem_win
		##1 ce_i [*3] |=> rdy_o
	) else $error("wait states too long");

	chk_zws_pulse: assert property (
		ce_i && zero_wait_indication_o |=> !zero_wait_indication_o
	) else $error("zero-wait indication longer than one cycle");

	chk_rdata_idle: assert property (
		ce_i && !reg_req_i.rd |=> reg_rdata_o == 8'h00
	) else $error("read data outside its read cycle");

	chk_alt_rom_off: assert property (
		ce_i && !bus_is_isa_o |=> xcvr_en_n_o
	) else $error("rom transceivers enabled on alternate bus");

	cov_zws_write: cover property (
		st.cyc == HSCPD_IDLE && memw_rise && vmem_win && zws_active
	);

	cov_ext_palette: cover property (
		host_q.iord && palx_win && st.ext_ctrl[EXT_DAC_BIT]
	);

	cov_rom_read: cover property (
		host_q.memr && rom_win && rom_dec_en
	);

	cov_wait_read: cover property (
		st.cyc == HSCPD_IDLE && memr_rise && vmem_win
	);

endmodule : hscpd_top

/* verif/hscpd_host_model.sv */
// host bus and strap driver standing in for the system side
`timescale 1ns/1ps
module hscpd_host_model
	import hscpd_pkg::*;
(
	input wire logic core_clk_i,
	output hscpd_pkg::hscpd_host_bus_t host_bus_o,
	output logic [7:0] ad_o,
	output logic [7:0] ad_oe_o
);
	initial begin
		host_bus_o = '0;
		ad_o = 8'h00;
		ad_oe_o = 8'h00;
	end
	// zero straps pulled low, one straps left to the pull-ups
	task automatic strap(input logic [7:0] v);
		ad_oe_o <= ~v;
	endtask : strap
	task automatic release_ad();
		ad_oe_o <= 8'h00;
	endtask : release_ad
	// k = {memr, memw, iord, iowr}
	task automatic go(input logic [3:0] k, input logic [19:0] a);
		@(posedge core_clk_i);
		host_bus_o <= {a, a[15:0], k};
	endtask : go
	// released address lines show no stale value
	task automatic done();
		@(posedge core_clk_i);
		host_bus_o <= {~host_bus_o.mem_addr, ~host_bus_o.io_addr, 4'h0};
		repeat (4) @(posedge core_clk_i);
	endtask : done
endmodule : hscpd_host_model

/* verif/testbench.sv */
// self-checking bench for strap capture, lock and port decode
`timescale 1ns/1ps
module testbench;
	import hscpd_pkg::*;
	logic core_clk_i = 0;
	logic nrst_i = 0;
	hscpd_reg_req_t req = '0;
	hscpd_host_bus_t hb;
	logic [7:0] ad, ad_oe, ad_pu, ad_res, d_o, d_oe, rdata, bad_count = 0;
	logic isa, pix, one, prd, pwr, rom_n, xcv_n, zero_wait_indication, rdy, claim;
	logic [1:0] up, up_oe;
	int n_tests = 0;
	int cyc = 0;
	logic ce = 1'b1;
	always #4 core_clk_i = ~core_clk_i;
	// wire level: model drive, else the pull-up
	always_comb ad_res = (ad_oe & ad) | (~ad_oe & ad_pu);
	hscpd_host_model host (.core_clk_i(core_clk_i), .host_bus_o(hb), .ad_o(ad), .ad_oe_o(ad_oe));
	hscpd_top dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(ce), .host_bus_i(hb),
		.host_addr_data_lines_i(ad_res), .host_addr_data_lines_o(d_o),
		.host_addr_data_lines_oe_o(d_oe), .host_addr_data_pullup_o(ad_pu), .reg_req_i(req),
		.reg_rdata_o(rdata), .bus_is_isa_o(isa), .pix_clk_from_osc_o(pix),
		.upper_clock_pins_o(up), .upper_clock_pins_oe_o(up_oe), .mem_clk_from_one_o(one),
		.pal_rd_n_o(prd), .pal_wr_n_o(pwr), .bios_rom_select_n_o(rom_n), .xcvr_en_n_o(xcv_n),
		.zero_wait_indication_o(zero_wait_indication), .rdy_o(rdy), .host_16bit_claim_o(claim));
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			$display("unexpected %s: expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk_i);
		req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk_i);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk_i);
		req.rd <= 1'b0;
		#1 chk("rdata", e, rdata);
	endtask : rd
	task automatic do_reset(input logic [7:0] v);
		@(posedge core_clk_i);
		nrst_i <= 1'b0;
		host.strap(v);
		repeat (12) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		@(posedge core_clk_i);
		host.release_ad();
	endtask : do_reset
	task automatic t_strap(input logic [7:0] v);
		rd(REG_EXT_CTRL, 8'h00);
		rd(REG_STRAP, v);
		wr(REG_STRAP, ~v);
		rd(REG_STRAP, v);
		rd(8'h3f, 8'h00);
		chk("bus_is_isa", {7'h0, v[0]}, {7'h0, isa});
		chk("pix_osc", {7'h0, v[2]}, {7'h0, pix});
		chk("upper_oe", {6'h0, {2{~v[2]}}}, {6'h0, up_oe});
		chk("mclk_one", {7'h0, ~v[3]}, {7'h0, one});
		chk("pullup", 8'hff, ad_pu);
		chk("ad_oe", 8'h00, d_oe);
		chk("ad_out", 8'h00, d_o);
		chk("claim16", 8'h00, {7'h0, claim});
		$display("test strap %h done", v);
	endtask : t_strap
	task automatic t_pal(input logic ext);
		logic [15:0] al [8];
		logic hit;
		al = '{16'h03c5, 16'h03c6, 16'h03c7, 16'h03c8, 16'h03c9, 16'h03ca, 16'h83c6, 16'h83c9};
		for (int i = 0; i < 16; i++) begin
			hit = (al[i%8][15:4] == 12'h03c && al[i%8][3:0] inside {[4'h6:4'h9]})
				|| (ext && al[i%8][15:4] == 12'h83c && al[i%8][3:0] inside {[4'h6:4'h9]});
			host.go(i < 8 ? 4'h2 : 4'h1, {4'h0, al[i%8]});
			repeat (3) @(posedge core_clk_i);
			#1 chk("pal_rd_n", {7'h0, ~(hit && i < 8)}, {7'h0, prd});
			chk("pal_wr_n", {7'h0, ~(hit && i >= 8)}, {7'h0, pwr});
			host.done();
		end
		$display("test palette ext=%0d done", ext);
	endtask : t_pal
	task automatic t_rom(input logic on);
		logic [19:0] al [4];
		logic hit;
		al = '{20'hc0000, 20'hc7fff, 20'hc8000, 20'hd0000};
		for (int i = 0; i < 4; i++) begin
			hit = on && i < 2;
			host.go(4'h8, al[i]);
			repeat (3) @(posedge core_clk_i);
			#1 chk("rom_sel_n", {7'h0, ~hit}, {7'h0, rom_n});
			chk("xcvr_n", {7'h0, ~hit}, {7'h0, xcv_n});
			host.done();
		end
		$display("test rom done");
	endtask : t_rom
	task automatic t_lock();
		wr(REG_EXT_CTRL, 8'h03);
		rd(REG_EXT_CTRL, 8'h00);
		wr(REG_EN_A, 8'h01);
		wr(REG_EXT_CTRL, 8'h03);
		rd(REG_EXT_CTRL, 8'h00);
		wr(REG_EN_B, 8'h01);
		wr(REG_EXT_CTRL, 8'h03);
		rd(REG_EXT_CTRL, 8'h03);
		wr(REG_STD_MISC, 8'h0c);
		rd(REG_STD_MISC, 8'h0c);
		chk("upper_pins", 8'h03, {6'h0, up});
		// a write while the clock enable is low must not land
		@(posedge core_clk_i);
		ce <= 1'b0;
		wr(REG_STD_MISC, 8'h00);
		@(posedge core_clk_i);
		ce <= 1'b1;
		rd(REG_STD_MISC, 8'h0c);
		$display("test lock done");
	endtask : t_lock
	task automatic t_zws(input logic on);
		host.go(4'h4, 20'ha0000);
		repeat (3) @(posedge core_clk_i);
		#1 chk("zws", {7'h0, on}, {7'h0, zero_wait_indication});
		chk("zws_pin", {7'h0, ~on}, {7'h0, rom_n});
		chk("rdy_w", {7'h0, on}, {7'h0, rdy});
		@(posedge core_clk_i);
		#1 chk("zws_end", 8'h00, {7'h0, zero_wait_indication});
		host.done();
		host.go(4'h8, 20'ha0000);
		repeat (3) @(posedge core_clk_i);
		#1 chk("rdy_r", 8'h00, {7'h0, rdy});
		chk("zws_r", 8'h00, {7'h0, zero_wait_indication});
		repeat (3) @(posedge core_clk_i);
		#1 chk("rdy_end", 8'h01, {7'h0, rdy});
		host.done();
		$display("test zero wait %0d done", on);
	endtask : t_zws
	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : results
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			results();
		end
	end
	initial begin
		do_reset(8'he3);
		t_strap(8'he3);
		t_pal(1'b0);
		t_rom(1'b1);
		t_zws(1'b0);
		t_lock();
		t_pal(1'b1);
		t_zws(1'b1);
		do_reset(8'h1c);
		t_strap(8'h1c);
		t_rom(1'b0);
		t_zws(1'b0);
		results();
	end
endmodule : testbench
